// *** pkg/flash_protect_pkg.sv ***
// Constants for the flash sector protection block: register map,
// field positions, reset values, range bounds and command codes.
// Assumes a 16-bit flash address space and an 8-bit register file.
package flash_protect_pkg;

   // Register byte addresses on the AXI4-Lite bus
   localparam logic [7:0] ADDR_PROTECT = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0C;

   // Fields of sector_protect_register
   localparam int POL_BIT = 7;
   localparam int SPARE_BIT = 6;
   localparam int HDIS_BIT = 5;
   localparam int HSIZE_HI = 4;
   localparam int HSIZE_LO = 3;
   localparam int LDIS_BIT = 2;
   localparam int LSIZE_HI = 1;
   localparam int LSIZE_LO = 0;

   // Fields of flash_status_register and of the mask register
   localparam int STAT_VIOL_BIT = 5;
   localparam int STAT_LAUNCH_BIT = 0;
   localparam logic [7:0] STAT_IMPL = 8'h21;

   // Values after reset
   localparam logic [7:0] PROTECT_RST = 8'hFF;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;

   // Flash location of the protection byte restored at reset
   localparam logic [15:0] PROTECT_NVM_ADDR = 16'hFF0D;

   // Range bounds: high ranges end at the top, low ranges start at base
   localparam logic [15:0] HIGH_BASE_2K = 16'hF800;
   localparam logic [15:0] HIGH_BASE_4K = 16'hF000;
   localparam logic [15:0] HIGH_BASE_8K = 16'hE000;
   localparam logic [15:0] HIGH_BASE_16K = 16'hC000;
   localparam logic [15:0] LOW_BASE = 16'h4000;
   localparam logic [15:0] LOW_END_1K = 16'h43FF;
   localparam logic [15:0] LOW_END_2K = 16'h47FF;
   localparam logic [15:0] LOW_END_4K = 16'h4FFF;
   localparam logic [15:0] LOW_END_8K = 16'h5FFF;

   // Flash commands seen by the protection check
   localparam logic [1:0] OP_PROGRAM = 2'h0;
   localparam logic [1:0] OP_SECTOR_ERASE = 2'h1;
   localparam logic [1:0] OP_MASS_ERASE = 2'h2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Controller states
   typedef enum logic [1:0]
   {
      ST_LOAD = 2'b01,
      ST_READY = 2'b10
   } prot_state_t;

endpackage : flash_protect_pkg

// *** rtl/flash_sector_protection.sv ***
// Flash sector protection: protection register, write restrictions,
// reset-time load, range check on program/erase and violation flag.
// Assumes the flash array presents the byte at the protection address
// on nvm_protect_byte and the command controller runs on aclk.
//
// Summary of operation
// - Protection register readable in every mode
// - Polarity bit only clears, never sets
// - Low size writable only while low disabled
// - High size writable only while high disabled
// - Reset loads register from flash byte FF0D
// - Protected program or erase refused, flags violation
// - Mass erase needs polarity and both disables
// - Polarity one: cleared disable protects range
// - Polarity zero: cleared disable opens window
// - High size selects 2K to 16K top
// - Low size selects 1K to 8K from 4000
// - Bit layout of the protection register
// - Software may change protection at run time
// - Disallowed scenario write ignored; only add protection
// - Violation flag blocks commands; write one clears
`timescale 1ns/1ps

module flash_sector_protection
   import flash_protect_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] nvm_protect_byte,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [15:0] cmd_addr,
   output logic cmd_launch,
   output logic cmd_refuse,
   output logic protection_violation_flag,
   output logic irq
);

   prot_state_t state_r;
   logic [7:0] sector_protect_register;
   logic [7:0] status_r;
   logic [7:0] mask_r;
   logic [7:0] awaddr_r;
   logic [7:0] wdata_r;
   logic wstrb0_r;
   logic aw_held_r;
   logic w_held_r;
   logic aw_held_nxt;
   logic w_held_nxt;
   logic aw_hs;
   logic w_hs;
   logic wr_do;
   logic ar_hs;
   logic prot_we;
   logic status_w1c;
   logic mask_we;
   logic [7:0] prot_nxt;
   logic [7:0] read_val;
   logic cmd_bad;
   logic cmd_ok;
   logic set_viol;

   // True when addr falls in the high range chosen by size
   function automatic logic in_high(input logic [15:0] addr,
                                    input logic [1:0] size);
      logic [15:0] base;
      case (size)
         2'h0: base = HIGH_BASE_2K;
         2'h1: base = HIGH_BASE_4K;
         2'h2: base = HIGH_BASE_8K;
         default: base = HIGH_BASE_16K;
      endcase
      return addr >= base;
   endfunction : in_high

   // True when addr falls in the low range chosen by size
   function automatic logic in_low(input logic [15:0] addr,
                                   input logic [1:0] size);
      logic [15:0] last;
      case (size)
         2'h0: last = LOW_END_1K;
         2'h1: last = LOW_END_2K;
         2'h2: last = LOW_END_4K;
         default: last = LOW_END_8K;
      endcase
      return (addr >= LOW_BASE) && (addr <= last);
   endfunction : in_low

   // Protection of one address under a given register setting
   function automatic logic is_protected(input logic [15:0] addr,
                                         input logic [7:0] cfg);
      logic hit;
      hit = (!cfg[HDIS_BIT] && in_high(addr, cfg[HSIZE_HI:HSIZE_LO]))
         || (!cfg[LDIS_BIT] && in_low(addr, cfg[LSIZE_HI:LSIZE_LO]));
      // Polarity one: hit ranges protected
      // Polarity zero: hit ranges are windows, rest protected
      return cfg[POL_BIT] ? hit : !hit;
   endfunction : is_protected

   // One range may leave protection only if it was already open
   function automatic logic range_ok(input logic old_pol,
                                     input logic old_dis,
                                     input logic new_pol,
                                     input logic new_dis);
      logic ok;
      if (new_pol)
         ok = new_dis ? old_dis : 1'b1;
      else if (new_dis)
         ok = 1'b1;
      else
         ok = old_pol ? old_dis : !old_dis;
      return ok;
   endfunction : range_ok

   // Write channel handshakes; address and data taken in either order
   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign wr_do = aw_held_r && w_held_r && !bvalid;
   assign ar_hs = arvalid && arready;

   // Holding flags for the write channels
   always_comb
   begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      if (wr_do)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
      end
      if (aw_hs)
         aw_held_nxt = 1'b1;
      if (w_hs)
         w_held_nxt = 1'b1;
   end

   // Write address capture and ready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awready <= 1'b0;
         awaddr_r <= 8'h00;
      end
      else
      begin
         aw_held_r <= aw_held_nxt;
         awready <= !aw_held_nxt;
         if (aw_hs)
            awaddr_r <= awaddr;
      end
   end

   // Write data capture and ready; only byte lane 0 is implemented
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wready <= 1'b0;
         wdata_r <= 8'h00;
         wstrb0_r <= 1'b0;
      end
      else
      begin
         w_held_r <= w_held_nxt;
         wready <= !w_held_nxt;
         if (w_hs)
         begin
            wdata_r <= wdata[7:0];
            wstrb0_r <= wstrb[0];
         end
      end
   end

   // Write response, one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (wr_do)
      begin
         bvalid <= 1'b1;
         if (awaddr_r == ADDR_PROTECT || awaddr_r == ADDR_STATUS
             || awaddr_r == ADDR_MASK)
            bresp <= RESP_OKAY;
         else
            bresp <= RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // Register write strobes
   always_comb
   begin
      prot_we = 1'b0;
      status_w1c = 1'b0;
      mask_we = 1'b0;
      if (!wr_do || !wstrb0_r)
      begin
         prot_we = 1'b0;
      end
      else if (awaddr_r == ADDR_PROTECT)
         prot_we = 1'b1;
      else if (awaddr_r == ADDR_STATUS)
         status_w1c = 1'b1;
      else if (awaddr_r == ADDR_MASK)
         mask_we = 1'b1;
   end

   // Candidate protection value under the per-field write limits
   always_comb
   begin
      prot_nxt = wdata_r;
      // Polarity can only fall
      prot_nxt[POL_BIT] = sector_protect_register[POL_BIT]
                          && wdata_r[POL_BIT];
      // Size fields frozen once their disable bit is clear
      if (!sector_protect_register[HDIS_BIT])
         prot_nxt[HSIZE_HI:HSIZE_LO] =
            sector_protect_register[HSIZE_HI:HSIZE_LO];
      if (!sector_protect_register[LDIS_BIT])
         prot_nxt[LSIZE_HI:LSIZE_LO] =
            sector_protect_register[LSIZE_HI:LSIZE_LO];
   end

   // Controller state: one load cycle after reset, then ready
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state_r <= ST_LOAD;
      else
      begin
         case (state_r)
            ST_LOAD: state_r <= ST_READY;
            ST_READY: state_r <= ST_READY;
            default: state_r <= ST_LOAD;
         endcase
      end
   end

   // Protection register: flash byte at load, guarded writes after
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sector_protect_register <= PROTECT_RST;
      else if (state_r == ST_LOAD)
         sector_protect_register <= nvm_protect_byte;
      else if (prot_we
               && range_ok(sector_protect_register[POL_BIT],
                           sector_protect_register[HDIS_BIT],
                           prot_nxt[POL_BIT], prot_nxt[HDIS_BIT])
               && range_ok(sector_protect_register[POL_BIT],
                           sector_protect_register[LDIS_BIT],
                           prot_nxt[POL_BIT], prot_nxt[LDIS_BIT]))
         sector_protect_register <= prot_nxt;
   end

   // Command check: a raised violation flag blocks everything
   always_comb
   begin
      cmd_bad = 1'b0;
      if (cmd_op == OP_MASS_ERASE)
         cmd_bad = !(sector_protect_register[POL_BIT]
                     && sector_protect_register[HDIS_BIT]
                     && sector_protect_register[LDIS_BIT]);
      else if (cmd_op == OP_PROGRAM || cmd_op == OP_SECTOR_ERASE)
         cmd_bad = is_protected(cmd_addr, sector_protect_register);
   end

   assign set_viol = cmd_valid && state_r == ST_READY
                     && !status_r[STAT_VIOL_BIT] && cmd_bad;
   assign cmd_ok = cmd_valid && state_r == ST_READY
                   && !status_r[STAT_VIOL_BIT] && !cmd_bad;

   // Launch and refuse pulses toward the command controller
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmd_launch <= 1'b0;
         cmd_refuse <= 1'b0;
      end
      else
      begin
         cmd_launch <= cmd_ok;
         cmd_refuse <= cmd_valid && !cmd_ok;
      end
   end

   // Sticky status bits; a same-cycle event beats the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_r <= STATUS_RST;
      else
      begin
         status_r <= (status_r & ~({8{status_w1c}} & wdata_r))
                     & STAT_IMPL;
         if (set_viol)
            status_r[STAT_VIOL_BIT] <= 1'b1;
         if (cmd_ok)
            status_r[STAT_LAUNCH_BIT] <= 1'b1;
      end
   end

   // Interrupt mask, same layout as the status register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_r <= MASK_RST;
      else if (mask_we)
         mask_r <= wdata_r & STAT_IMPL;
   end

   // Registered copies of flag and interrupt; lag status by one cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         protection_violation_flag <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         protection_violation_flag <= status_r[STAT_VIOL_BIT];
         irq <= |(status_r & mask_r);
      end
   end

   // Read decode; register readable whatever the operating mode
   always_comb
   begin
      read_val = 8'h00;
      if (araddr == ADDR_PROTECT)
         read_val = sector_protect_register;
      else if (araddr == ADDR_STATUS)
         read_val = status_r;
      else if (araddr == ADDR_MASK)
         read_val = mask_r;
   end

   // Read channel: one read at a time, answered next cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, read_val};
         if (araddr == ADDR_PROTECT || araddr == ADDR_STATUS
             || araddr == ADDR_MASK)
            rresp <= RESP_OKAY;
         else
            rresp <= RESP_SLVERR;
      end
      else if (rvalid)
      begin
         if (rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
      else
         arready <= 1'b1;
   end

endmodule : flash_sector_protection

// *** verification/flash_protect_checker.sv ***
// Checker for the flash protection block: command answers, violation
// flag, interrupt and bus timing. Bound to the top ports, one clock.
`timescale 1ns/1ps

module flash_protect_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic cmd_valid,
   input wire logic cmd_launch,
   input wire logic cmd_refuse,
   input wire logic protection_violation_flag,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Command issued, then flag seen in the deciding cycle
   sequence s_flagged_cmd;
      cmd_valid ##1 protection_violation_flag;
   endsequence
   // Both write halves taken together
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence

   AST_ONE_ANSWER: assert property (
      cmd_valid |=> cmd_launch ^ cmd_refuse)
      else $error("command not answered exactly once");
   AST_NO_STRAY: assert property (
      !cmd_valid |=> !(cmd_launch || cmd_refuse))
      else $error("answer without a command");
   AST_FLAG_BLOCKS: assert property (
      s_flagged_cmd |-> cmd_refuse)
      else $error("command launched while flag set");
   AST_LAUNCH_CLEAN: assert property (
      cmd_launch |-> !protection_violation_flag)
      else $error("launch with flag set");
   AST_FLAG_CAUSE: assert property (
      $rose(protection_violation_flag) |-> $past(cmd_refuse))
      else $error("flag rose without a refusal");
   AST_FLAG_CLEAR: assert property (
      $fell(protection_violation_flag) |-> $past(bvalid))
      else $error("flag fell without a write");
   AST_WR_RESP: assert property (
      s_wr_taken |-> ##2 bvalid)
      else $error("write response late");
   AST_B_DONE: assert property (
      bvalid && bready |=> !bvalid)
      else $error("write response not released");
   AST_RD_RESP: assert property (
      arvalid && arready |=> rvalid)
      else $error("read response late");
   AST_RD_UPPER: assert property (
      rvalid |-> rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   AST_IRQ_CAUSE: assert property (
      $rose(irq) |-> $past(cmd_refuse || cmd_launch || bvalid))
      else $error("interrupt rose without cause");
endmodule : flash_protect_checker

// *** verification/tb_top.sv ***
// Self-checking bench for the flash protection block.
// Drives the AXI4-Lite bus and command port directly, no partner.
`timescale 1ns/1ps

module tb_top
   import flash_protect_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [7:0] nvm_protect_byte = 8'hFF;
   logic [31:0] wdata = 32'h00000000;
   logic [15:0] cmd_addr = 16'h0000;
   logic [1:0] cmd_op = 2'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, cmd_valid = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, cmd_launch;
   logic cmd_refuse, protection_violation_flag, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] hb, le;
   logic [7:0] pb;
   int n_errors = 0, check_count = 0, cyc = 0;

   flash_sector_protection DUT (.aclk, .aresetn, .awaddr,
      .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .nvm_protect_byte, .cmd_valid, .cmd_op, .cmd_addr, .cmd_launch,
      .cmd_refuse, .protection_violation_flag, .irq);

   // 50 MHz clock
   initial
   begin
      forever #10 aclk = ~aclk;
   end

   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk

   // Reset with a given stored byte; byte flips after the load edge
   task automatic rst(input logic [7:0] b);
      @(posedge aclk);
      aresetn <= 1'b0;
      nvm_protect_byte <= b;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      nvm_protect_byte <= ~b; // A reload would now show up
   endtask : rst

   // Readies are sampled at negedge, stable up to the next edge
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                         input logic [1:0] er);
      logic ga, gw, ra, rw;
      logic [1:0] r;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ga = 1'b0;
      gw = 1'b0;
      while (!(ga && gw))
      begin
         @(negedge aclk);
         ra = awready;
         rw = wready;
         @(posedge aclk);
         if (ra && !ga)
         begin
            ga = 1'b1;
            awvalid <= 1'b0;
         end
         if (rw && !gw)
         begin
            gw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do
      begin
         @(negedge aclk);
         ra = bvalid;
         r = bresp;
         @(posedge aclk);
      end while (!ra);
      bready <= 1'b0;
      chk(r, er);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [7:0] e,
                         input logic [1:0] er);
      logic g;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         g = arready;
         @(posedge aclk);
      end while (!g);
      arvalid <= 1'b0;
      do
      begin
         @(negedge aclk);
         g = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
      end while (!g);
      rready <= 1'b0;
      chk(d, {24'h000000, e});
      chk(r, er);
   endtask : axi_rd

   // One-cycle command; a refusal must also leave the flag set
   task automatic cmd(input logic [1:0] op, input logic [15:0] a,
                      input logic ok);
      @(posedge aclk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      @(posedge aclk);
      cmd_valid <= 1'b0;
      #1;
      chk(cmd_launch, ok);
      chk(cmd_refuse, !ok);
      if (!ok)
      begin
         @(posedge aclk);
         #1;
         chk(protection_violation_flag, 1'b1);
      end
   endtask : cmd

   task automatic clr;
      axi_wr(ADDR_STATUS, 8'h20, RESP_OKAY);
   endtask : clr

   // Hang guard, far above the few hundred cycles needed
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         test_done();
      end
   end

   // Main sequence
   initial
   begin
      for (int c = 0; c < 4; c++)
      begin
         pb = {2'b11, 1'b0, 2'(c), 1'b0, 2'(c)}; // Spare bit erased
         hb = 16'(17'h10000 - (17'h00800 << c));
         le = 16'(16'h4000 + (16'h0400 << c) - 16'h0001);
         rst(pb);
         axi_rd(ADDR_PROTECT, pb, RESP_OKAY);
         cmd(OP_PROGRAM, hb - 16'h0001, 1'b1);
         cmd(OP_SECTOR_ERASE, le + 16'h0001, 1'b1);
         cmd(OP_PROGRAM, 16'h3FFF, 1'b1);
         cmd(OP_MASS_ERASE, 16'h0000, 1'b0);
         cmd(OP_PROGRAM, 16'h8000, 1'b0);
         axi_rd(ADDR_STATUS, 8'h21, RESP_OKAY);
         chk(irq, 1'b0);
         clr;
         cmd(OP_SECTOR_ERASE, hb, 1'b0);
         clr;
         cmd(OP_PROGRAM, le, 1'b0);
         clr;
         cmd(OP_PROGRAM, 16'h4000, 1'b0);
         clr;
      end
      axi_wr(ADDR_PROTECT, 8'hC0, RESP_OKAY);
      axi_rd(ADDR_PROTECT, 8'hDB, RESP_OKAY);
      axi_wr(ADDR_PROTECT, 8'hFF, RESP_OKAY);
      axi_rd(ADDR_PROTECT, 8'hDB, RESP_OKAY);
      rst(8'hFF);
      cmd(OP_MASS_ERASE, 16'h0000, 1'b1);
      cmd(OP_PROGRAM, 16'hFFFF, 1'b1);
      cmd(OP_PROGRAM, PROTECT_NVM_ADDR, 1'b1);
      axi_wr(ADDR_PROTECT, 8'hE0, RESP_OKAY);
      axi_rd(ADDR_PROTECT, 8'hE0, RESP_OKAY);
      cmd(OP_MASS_ERASE, 16'h0000, 1'b0);
      clr;
      axi_wr(ADDR_PROTECT, 8'h7F, RESP_OKAY);
      axi_rd(ADDR_PROTECT, 8'h7C, RESP_OKAY);
      cmd(OP_PROGRAM, 16'h8000, 1'b0);
      clr;
      axi_wr(ADDR_PROTECT, 8'hFF, RESP_OKAY);
      axi_rd(ADDR_PROTECT, 8'h7F, RESP_OKAY);
      rst(8'h5F);
      cmd(OP_PROGRAM, 16'hC000, 1'b1);
      cmd(OP_PROGRAM, 16'hBFFF, 1'b0);
      chk(irq, 1'b0);
      axi_wr(ADDR_MASK, 8'h20, RESP_OKAY);
      @(negedge aclk);
      chk(irq, 1'b1);
      axi_rd(ADDR_MASK, 8'h20, RESP_OKAY);
      clr;
      @(negedge aclk);
      chk(irq, 1'b0);
      chk(protection_violation_flag, 1'b0);
      axi_wr(8'h10, 8'hFF, RESP_SLVERR);
      axi_rd(8'h10, 8'h00, RESP_SLVERR);
      test_done();
   end
endmodule : tb_top

bind flash_sector_protection flash_protect_checker chk_i (.aclk,
   .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
   .arvalid, .arready, .rvalid, .rdata, .cmd_valid, .cmd_launch,
   .cmd_refuse, .protection_violation_flag, .irq);
